// File: rtl/loop_slave_pkg.sv
// Constants shared by the loop slave packet framer.
// Assumes a single 250 MHz system clock and synchronous active-high reset.
package loop_slave_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned LINK_KBPS = 1200;
    localparam int unsigned BIT_CYCLES = (CLK_MHZ * 1000) / LINK_KBPS;
    localparam logic [7:0] FLAG_BYTE = 8'h7e;
    // A zero then seven ones, LSB first; the last one becomes a zero on claim.
    localparam logic [7:0] EOP_BYTE = 8'hfe;
    localparam int unsigned MAX_PAYLOAD = 256;
    localparam int unsigned MAX_OUTSTANDING = 7;
    localparam int unsigned HOST_FIFO_DEPTH = 16;
    localparam int unsigned TX_FIFO_DEPTH = 3;
    localparam int unsigned ONES_LIMIT = 5;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESET = 16'h0000;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WAIT = 6'b000010,
        ST_CLAIM = 6'b000100,
        ST_BODY = 6'b001000,
        ST_FCS = 6'b010000,
        ST_CLOSE = 6'b100000
    } tx_state_t;
endpackage : loop_slave_pkg

// File: rtl/loop_slave_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, a clock enable and synchronous reset.
`default_nettype none
module loop_slave_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clocking.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Fill side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clk_en) begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : loop_slave_fifo
`default_nettype wire

// File: rtl/loop_slave_framer.sv
// Slave station packet framer for a loop ring.
// Assumes host bytes arrive from a 16-byte receive FIFO with a timeout
// strobe, ring bits are sampled per bit period, and acks come decoded.
`default_nettype none
module loop_slave_framer
    import loop_slave_pkg::*;
#(
    parameter int unsigned BIT_TICKS = BIT_CYCLES,
    parameter int STORE_DEPTH = 8,
    parameter int BUF_DEPTH = 8
) (
    // Clocking.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Station addresses.
    input wire logic [7:0] dest_addr,
    input wire logic [7:0] src_addr,
    // Host receive FIFO side.
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    input wire logic host_timeout,
    output logic host_ready,
    // Decoded acknowledgements.
    input wire logic ack_valid,
    input wire logic ack_bad,
    input wire logic [2:0] ack_seq,
    // Ring pins and the outstanding frame count.
    input wire logic ring_rx,
    output logic ring_tx,
    output logic [3:0] outstanding
);
    localparam int PW = 8 + 3;
    localparam int CW = $clog2(BIT_TICKS + 1);
    // Packet storage: STORE_DEPTH slots of MAX_PAYLOAD bytes each.
    logic [7:0] store [STORE_DEPTH * MAX_PAYLOAD];
    logic [8:0] store_len [STORE_DEPTH];
    logic [2:0] head, tail, send_ptr;
    logic [3:0] used;
    logic [8:0] fill_cnt;
    logic pkt_ready;
    // Bit timing and input synchroniser.
    logic [CW-1:0] tick_cnt;
    logic rx_s1, rx_s2, rx_bit;
    logic [7:0] rx_shift;
    tx_state_t state;
    logic [8:0] idx, body_len;
    logic [7:0] tx_byte;
    logic [3:0] bitn;
    logic [2:0] ones;
    logic [15:0] crc;
    logic [2:0] seq_base;
    // FIFO between host side and packet storage.
    logic buf_valid, buf_ready;
    logic [7:0] buf_data;
    loop_slave_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(host_valid),
        .in_data(host_data),
        .in_ready(host_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_ready)
    );
    wire tick = tick_cnt == CW'(BIT_TICKS - 1);
    wire store_full = used == 4'(STORE_DEPTH);
    wire window_full = used >= 4'(MAX_OUTSTANDING);
    assign buf_ready = !store_full && !pkt_ready;
    wire take = buf_valid && buf_ready;
    wire close_pkt = (take && fill_cnt == 9'(MAX_PAYLOAD - 1))
        || (host_timeout && !buf_valid && fill_cnt != '0 && !pkt_ready);
    wire eop_seen = tick && {rx_bit, rx_shift[7:1]} == EOP_BYTE;
    wire has_work = send_ptr != tail || pkt_ready;
    wire stuff_now = ones == 3'(ONES_LIMIT);
    wire cur_bit = tx_byte[bitn[2:0]];
    wire crc_fb = crc[0] ^ cur_bit;
    wire [15:0] crc_next = {1'b0, crc[15:1]} ^ (crc_fb ? CRC_POLY : '0);
    wire [2:0] seq_now = seq_base + (send_ptr - head);
    wire [7:0] body_byte = (idx == 9'd0) ? dest_addr :
        (idx == 9'd1) ? src_addr :
        (idx == 9'd2) ? {5'h00, seq_now} :
        store[{send_ptr, 8'(idx - 9'd3)}];
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick_cnt <= '0;
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_bit <= 1'b1;
        end else if (clk_en) begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
            rx_s1 <= ring_rx;
            rx_s2 <= rx_s1;
            if (tick) begin
                rx_bit <= rx_s2;
            end
        end
    end
    // Storage fill and release.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tail <= '0;
            head <= '0;
            used <= '0;
            fill_cnt <= '0;
            pkt_ready <= 1'b0;
            seq_base <= '0;
        end else if (clk_en) begin
            if (take) begin
                store[{tail, fill_cnt[7:0]}] <= buf_data;
                fill_cnt <= fill_cnt + 1'b1;
            end
            if (close_pkt) begin
                pkt_ready <= 1'b1;
                store_len[tail] <= take ? fill_cnt + 1'b1 : fill_cnt;
            end
            if (state == ST_CLOSE && tick && bitn == 4'd7 && pkt_ready
                    && send_ptr == tail) begin
                pkt_ready <= 1'b0;
                tail <= tail + 1'b1;
                fill_cnt <= '0;
            end
            if (ack_valid && !ack_bad && used != '0) begin
                // Acks cover everything up to and including ack_seq.
                head <= head + (ack_seq - seq_base) + 1'b1;
                seq_base <= ack_seq + 1'b1;
            end
            used <= 4'(tail - head) + 4'(pkt_ready);
        end
    end
    // Transmit sequencer, one bit per tick.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            ring_tx <= 1'b1;
            send_ptr <= '0;
            rx_shift <= 8'hff;
            idx <= '0;
            bitn <= '0;
            ones <= '0;
            crc <= CRC_RESET;
            tx_byte <= FLAG_BYTE;
            body_len <= '0;
            outstanding <= '0;
        end else if (clk_en) begin
            outstanding <= used;
            if (ack_valid && ack_bad) begin
                send_ptr <= head + (ack_seq - seq_base);
            end
            if (tick) begin
                rx_shift <= {rx_bit, rx_shift[7:1]};
                case (state)
                    ST_IDLE, ST_WAIT: begin
                        ring_tx <= rx_bit;
                        if (has_work && !(window_full && send_ptr == tail)
                                && eop_seen) begin
                            state <= ST_CLAIM;
                            ring_tx <= 1'b0;
                            idx <= '0;
                            bitn <= '0;
                            ones <= '0;
                            crc <= CRC_INIT;
                            body_len <= store_len[send_ptr] + 9'd3;
                        end else begin
                            state <= has_work ? ST_WAIT : ST_IDLE;
                        end
                    end
                    ST_CLAIM: begin
                        state <= ST_BODY;
                        tx_byte <= body_byte;
                        ring_tx <= body_byte[0];
                        crc <= {1'b0, crc[15:1]} ^
                            ((crc[0] ^ body_byte[0]) ? CRC_POLY : '0);
                        ones <= body_byte[0] ? 3'd1 : 3'd0;
                        bitn <= 4'd1;
                    end
                    ST_BODY, ST_FCS: begin
                        if (stuff_now) begin
                            ring_tx <= 1'b0;
                            ones <= '0;
                        end else begin
                            ring_tx <= cur_bit;
                            ones <= cur_bit ? ones + 1'b1 : '0;
                            if (state == ST_BODY) begin
                                crc <= crc_next;
                            end
                            bitn <= bitn + 1'b1;
                            // The next byte loads with the last bit, so no
                            // idle bit slips in between bytes.
                            if (bitn == 4'd7) begin
                                bitn <= '0;
                                if (state == ST_BODY
                                        && idx + 1'b1 == body_len) begin
                                    state <= ST_FCS;
                                    tx_byte <= ~crc_next[7:0];
                                    idx <= '0;
                                end else if (state == ST_FCS
                                        && idx == 9'd1) begin
                                    state <= ST_CLOSE;
                                    tx_byte <= EOP_BYTE;
                                end else if (state == ST_FCS) begin
                                    idx <= 9'd1;
                                    tx_byte <= ~crc[15:8];
                                end else begin
                                    idx <= idx + 1'b1;
                                    tx_byte <= store[{send_ptr,
                                        8'(idx - 9'd2)}];
                                    if (idx + 1'b1 < 9'd3) begin
                                        tx_byte <= (idx == 9'd0) ? src_addr
                                            : {5'h00, seq_now};
                                    end
                                end
                            end
                        end
                    end
                    ST_CLOSE: begin
                        // A run of five ones at the end of the check
                        // sequence still needs its zero before the end-of-poll byte.
                        if (stuff_now) begin
                            ring_tx <= 1'b0;
                            ones <= '0;
                        end else begin
                            ring_tx <= tx_byte[bitn[2:0]];
                            bitn <= bitn + 1'b1;
                            if (bitn == 4'd7) begin
                                state <= ST_IDLE;
                                send_ptr <= send_ptr + 1'b1;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
    property p_full_stalls;
        @(posedge sys_clk) disable iff (reset) store_full |-> !buf_ready;
    endproperty
    a_full_stalls: assert property (p_full_stalls)
        else $error("storage full but host side still drained");
    property p_claim_zero;
        @(posedge sys_clk) disable iff (reset)
            (clk_en && tick && state == ST_WAIT && $past(state) != ST_CLAIM
             && eop_seen && send_ptr != tail && !window_full)
            |=> state == ST_CLAIM && !ring_tx;
    endproperty
    a_claim_zero: assert property (p_claim_zero)
        else $error("poll not claimed with a cleared flag bit");
    property p_repeat;
        @(posedge sys_clk) disable iff (reset)
            (clk_en && tick && state == ST_IDLE && !has_work)
            |=> ring_tx == $past(rx_bit);
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("ring bit not repeated while idle");
    property p_window;
        @(posedge sys_clk) disable iff (reset)
            used <= 4'(STORE_DEPTH);
    endproperty
    a_window: assert property (p_window)
        else $error("stored frame count overflowed");
    property p_stuff;
        @(posedge sys_clk) disable iff (reset)
            (clk_en && tick && state == ST_BODY && stuff_now) |=> !ring_tx;
    endproperty
    a_stuff: assert property (p_stuff)
        else $error("no zero after five ones");
    property p_close;
        @(posedge sys_clk) disable iff (reset)
            (state == ST_FCS) ##1 (state == ST_CLOSE) |-> tx_byte == EOP_BYTE;
    endproperty
    a_close: assert property (p_close)
        else $error("frame not closed with end-of-poll");
    property p_timeout;
        @(posedge sys_clk) disable iff (reset)
            (clk_en && host_timeout && !buf_valid && fill_cnt != '0
             && !pkt_ready) |=> pkt_ready;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout did not close short packet");
    property p_full_pkt;
        @(posedge sys_clk) disable iff (reset)
            (clk_en && take && fill_cnt == 9'(MAX_PAYLOAD - 1)) |=> pkt_ready;
    endproperty
    a_full_pkt: assert property (p_full_pkt)
        else $error("full packet not closed");
    c_claim: cover property (@(posedge sys_clk) state == ST_CLAIM);
    c_close: cover property (@(posedge sys_clk) state == ST_CLOSE);
    c_resend: cover property (@(posedge sys_clk) ack_valid && ack_bad);
endmodule : loop_slave_framer
`default_nettype wire

// File: verif/loop_host_model.sv
// Behavioural host controller as the slave sees it on its ring pins.
// Assumes the slave runs the same bit period in clock cycles.
`default_nettype none
module loop_host_model #(
    parameter int BIT_TICKS = 4
) (
    // Clocking.
    input wire logic sys_clk,
    input wire logic reset,
    // Ring.
    input wire logic ring_tx,
    output logic ring_rx,
    // Bench side.
    input wire logic poll_req,
    output int flag_cnt,
    output int eop_cnt,
    output logic [23:0] hdr
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] FLAG_PAT = 8'h7e;
    localparam logic [7:0] EOP_PAT = 8'hfe;
    int tick;
    int pend;
    int nsent;
    int ones;
    int nbits;
    logic in_frame;
    logic [7:0] win;
    logic [7:0] sr;
    initial ring_rx = 1'b1;
    always @(posedge sys_clk) begin
        if (reset) begin
            tick = 0;
            pend = 0;
            nsent = 0;
            flag_cnt = 0;
            eop_cnt = 0;
            in_frame = 1'b0;
            win = 8'hff;
            ring_rx <= 1'b1;
        end else begin
            if (poll_req) begin
                pend = pend + 1;
            end
            tick = (tick + 1) % BIT_TICKS;
            // The ring idles at marks; a poll is one end-of-poll byte.
            if (tick == 0) begin
                if (nsent == 0 && pend > 0) begin
                    sr = EOP_PAT;
                    nsent = 8;
                    pend = pend - 1;
                end
                ring_rx <= (nsent > 0) ? sr[0] : 1'b1;
                if (nsent > 0) begin
                    sr = sr >> 1;
                    nsent = nsent - 1;
                end
            end
            // Sampling mid-period sees each registered bit exactly once.
            if (tick == BIT_TICKS / 2) begin
                win = {ring_tx, win[7:1]};
                if (win == FLAG_PAT) begin
                    flag_cnt = flag_cnt + 1;
                    in_frame = 1'b1;
                    ones = 0;
                    nbits = 0;
                end else if (win == EOP_PAT) begin
                    eop_cnt = eop_cnt + 1;
                    in_frame = 1'b0;
                end else if (in_frame && ones == 5 && !ring_tx) begin
                    ones = 0;
                end else if (in_frame && nbits < 24) begin
                    hdr = {ring_tx, hdr[23:1]};
                    ones = ring_tx ? ones + 1 : 0;
                    nbits = nbits + 1;
                end
            end
        end
    end
endmodule : loop_host_model
`default_nettype wire

// File: verif/sdlc_loop_slave_packet_flow_tb.sv
// Self-checking bench for the loop slave framer with a host model.
// Assumes a short bit period parameter to keep frames brief.
`default_nettype none
module sdlc_loop_slave_packet_flow_tb;
    import loop_slave_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICKS = 4;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] dest_addr = 8'h00;
    logic [7:0] src_addr = 8'h00;
    logic host_valid = 1'b0;
    logic [7:0] host_data = 8'h00;
    logic host_timeout = 1'b0;
    logic ack_valid = 1'b0;
    logic ack_bad = 1'b0;
    logic [2:0] ack_seq = 3'h0;
    logic poll_req = 1'b0;
    logic host_ready;
    logic ring_rx;
    logic ring_tx;
    logic [3:0] outstanding;
    logic [23:0] hdr;
    int flag_cnt;
    int eop_cnt;
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'h6de80025;
    int f0;
    always #2 sys_clk = ~sys_clk;
    loop_slave_framer #(.BIT_TICKS(TICKS)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
        .dest_addr(dest_addr), .src_addr(src_addr),
        .host_valid(host_valid), .host_data(host_data),
        .host_timeout(host_timeout), .host_ready(host_ready),
        .ack_valid(ack_valid), .ack_bad(ack_bad), .ack_seq(ack_seq),
        .ring_rx(ring_rx), .ring_tx(ring_tx), .outstanding(outstanding)
    );
    loop_host_model #(.BIT_TICKS(TICKS)) host_u (
        .sys_clk(sys_clk), .reset(reset), .ring_tx(ring_tx),
        .ring_rx(ring_rx), .poll_req(poll_req), .flag_cnt(flag_cnt),
        .eop_cnt(eop_cnt), .hdr(hdr)
    );
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic summarize();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : check
    task automatic push(input int n);
        int guard;
        for (int i = 0; i < n; i++) begin
            host_valid = 1'b1;
            host_data = 8'($random(seed));
            guard = 0;
            while (host_ready !== 1'b1 && guard < 3000) begin
                step(1);
                guard++;
            end
            if (guard >= 3000) begin
                check("host_ready wait", 1, 0);
                summarize();
            end
            step(1);
        end
        host_valid = 1'b0;
    endtask : push
    // Sends one poll and waits for an end-of-poll to come back around.
    task automatic poll_frame();
        int guard;
        int e0;
        e0 = eop_cnt;
        f0 = flag_cnt;
        poll_req = 1'b1;
        step(1);
        poll_req = 1'b0;
        guard = 0;
        while (eop_cnt == e0 && guard < 20000) begin
            step(1);
            guard++;
        end
        check("eop count", e0 + 1, eop_cnt);
        if (guard >= 20000) begin
            summarize();
        end
        step(4);
    endtask : poll_frame
    task automatic ack(input logic bad, input logic [2:0] seq);
        ack_valid = 1'b1;
        ack_bad = bad;
        ack_seq = seq;
        step(1);
        ack_valid = 1'b0;
        step(4);
    endtask : ack
    // Short packet closed by a timeout, then sent on the next poll.
    task automatic short_frame(input logic [2:0] seq);
        push(1 + ($unsigned($random(seed)) % 4));
        step(3);
        host_timeout = 1'b1;
        step(1);
        host_timeout = 1'b0;
        step(20);
        poll_frame();
        check_hdr(seq);
    endtask : short_frame
    task automatic check_hdr(input logic [2:0] seq);
        check("flag count", f0 + 1, flag_cnt);
        check("dest byte", dest_addr, hdr[7:0]);
        check("src byte", src_addr, hdr[15:8]);
        check("control byte", {5'h00, seq}, hdr[23:16]);
    endtask : check_hdr
    initial begin
        dest_addr = 8'($random(seed));
        src_addr = 8'($random(seed));
        step(2);
        reset = 1'b0;
        step(1);
        check("ring_tx reset", 1, ring_tx);
        check("outstanding reset", 0, outstanding);
        check("host_ready reset", 1, host_ready);
        poll_frame();
        check("idle flag count", f0, flag_cnt);
        short_frame(3'h0);
        check("outstanding one", 1, outstanding);
        short_frame(3'h1);
        check("outstanding two", 2, outstanding);
        ack(1'b1, 3'h0);
        check("kept after bad ack", 2, outstanding);
        poll_frame();
        check_hdr(3'h0);
        poll_frame();
        check_hdr(3'h1);
        ack(1'b0, 3'h1);
        check("released", 0, outstanding);
        // A full packet plus a full host FIFO, with no poll offered.
        push(MAX_PAYLOAD + 8);
        step(8);
        check("host held off", 0, host_ready);
        check("waits for poll", 1, outstanding);
        poll_frame();
        check_hdr(3'h2);
        check("full frame kept", 1, outstanding);
        ack(1'b0, 3'h2);
        check("full frame released", 0, outstanding);
        summarize();
    end
endmodule : sdlc_loop_slave_packet_flow_tb
`default_nettype wire
